// ---- inc/ddce_pkg.sv ----
package ddce_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 32;
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_WINDOW    = 12'h004;
  localparam logic [11:0] OFF_STATUS    = 12'h008;

  // ctrl fields
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_MODE_MSB = 2;

  // status fields
  localparam int unsigned STAT_IN_A     = 0;
  localparam int unsigned STAT_IN_B     = 1;
  localparam int unsigned STAT_ST_LSB   = 2;
  localparam int unsigned STAT_ST_MSB   = 3;
  localparam int unsigned STAT_ENABLE   = 4;
  localparam int unsigned STAT_TIMEOUT  = 5;
  localparam int unsigned STAT_FAULT    = 6;
  localparam int unsigned STAT_ARMED    = 7;

  // ---------------------------------------------------------------
  // window and timing
  // ---------------------------------------------------------------
  localparam int unsigned WIN_W         = 12;
  localparam int unsigned STEP_MS       = 10;
  localparam int unsigned WIN_MAX_MS    = 30000;
  localparam logic [11:0] WIN_MAX_STEPS = 12'(WIN_MAX_MS / STEP_MS);
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STEP_CYCLES   = STEP_MS * 1000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // modes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MODE_EQUIV  = 2'b00,
    MODE_COMPL  = 2'b01,
    MODE_SINGLE = 2'b10
  } ddce_mode_t;

  typedef enum logic [1:0]
  {
    ST_DEACT  = 2'b00,
    ST_DISC   = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_ERROR  = 2'b11
  } ddce_state_t;

  localparam logic             RST_RUN    = 1'b0;
  localparam ddce_mode_t       RST_MODE   = MODE_EQUIV;
  localparam logic [WIN_W-1:0] RST_WINDOW = 12'h000;

endpackage

// ---- inc/ddce_tmr_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface ddce_tmr_if;
  import ddce_pkg::*;
  logic             start;
  logic             clear;
  logic [WIN_W-1:0] limit;
  logic             expired;

  modport ctrl (output start, output clear, output limit, input expired);
  modport tmr  (input start, input clear, input limit, output expired);
endinterface

`default_nettype wire

// ---- hdl/ddce_tick.sv ----
`timescale 1ns/100ps
`default_nettype none

module ddce_tick #(
  parameter int unsigned CYCLES = 1000000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic restart,
  output logic      tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;

  // restart keeps the first step a full one, so error is under one step
  always_comb
  begin
    if (restart || cnt == 32'(CYCLES - 1))
      next_cnt = 32'h00000000;
    else
      next_cnt = cnt + 32'h00000001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt <= 32'h00000000;
    else
      cnt <= next_cnt;
  end

  assign tick = !restart && (cnt == 32'(CYCLES - 1));
endmodule

`default_nettype wire

// ---- hdl/ddce_timer.sv ----
`timescale 1ns/100ps
`default_nettype none

module ddce_timer (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // step pulse
  input  wire logic tick,
  // control
  ddce_tmr_if.tmr   t
);
  import ddce_pkg::*;

  logic [WIN_W-1:0] cnt;
  logic [WIN_W-1:0] next_cnt;

  always_comb
  begin
    if (t.clear || t.start)
      next_cnt = '0;
    else if (tick && !t.expired)
      next_cnt = cnt + 12'h001;
    else
      next_cnt = cnt;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  // zero window never expires; count saturates once it reaches the limit
  assign t.expired = (t.limit != '0) && (cnt >= t.limit);
endmodule

`default_nettype wire

// ---- hdl/ddce_eval.sv ----
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module ddce_eval #(
  parameter int unsigned TICK_CYCLES = ddce_pkg::STEP_CYCLES
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ddce_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ddce_pkg::DATA_W-1:0]  pwdata,
  output logic      [ddce_pkg::DATA_W-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // sensor channels
  input  wire logic                         in_a,
  input  wire logic                         in_b,
  // evaluation outputs
  output logic                              enable,
  output logic                              timeout_err,
  output logic                              fault_flag
);
  import ddce_pkg::*;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic             run;
  ddce_mode_t       mode;
  logic [WIN_W-1:0] win_steps;
  logic             next_run;
  ddce_mode_t       next_mode;
  logic [WIN_W-1:0] next_win_steps;
  logic [31:0]      next_prdata;
  logic [31:0]      status_word;
  logic             wr_en;
  logic             mapped;

  ddce_state_t      state;
  logic             armed;

  assign mapped  = (paddr == OFF_CTRL) || (paddr == OFF_WINDOW) || (paddr == OFF_STATUS);
  assign wr_en   = psel && penable && pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    status_word                          = '0;
    status_word[STAT_IN_A]               = in_a;
    status_word[STAT_IN_B]               = in_b;
    status_word[STAT_ST_MSB:STAT_ST_LSB] = state;
    status_word[STAT_ENABLE]             = enable;
    status_word[STAT_TIMEOUT]            = timeout_err;
    status_word[STAT_FAULT]              = fault_flag;
    status_word[STAT_ARMED]              = armed;
  end

  always_comb
  begin
    next_run       = run;
    next_mode      = mode;
    next_win_steps = win_steps;
    next_prdata    = prdata;
    if (wr_en && paddr == OFF_CTRL)
    begin
      next_run = pwdata[CTRL_RUN_BIT];
      // mode is frozen while running; reserved code 2'b11 is refused
      if (!run && pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB] != 2'b11)
        next_mode = ddce_mode_t'(pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
    end
    if (wr_en && paddr == OFF_WINDOW && !run && pwdata[31:WIN_W] == '0
        && pwdata[WIN_W-1:0] <= WIN_MAX_STEPS)
      next_win_steps = pwdata[WIN_W-1:0];
    // read data captured in setup so it is a flop during access
    if (psel && !penable)
    begin
      case (paddr)
        OFF_CTRL:   next_prdata = {29'h0, mode, run};
        OFF_WINDOW: next_prdata = {20'h0, win_steps};
        OFF_STATUS: next_prdata = status_word;
        default:    next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run       <= RST_RUN;
      mode      <= RST_MODE;
      win_steps <= RST_WINDOW;
      prdata    <= 32'h00000000;
    end
    else
    begin
      run       <= next_run;
      mode      <= next_mode;
      win_steps <= next_win_steps;
      prdata    <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // mismatch timer
  // ---------------------------------------------------------------
  ddce_tmr_if tmr ();
  logic tick;

  ddce_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .rst     (rst),
    .restart (tmr.start),
    .tick    (tick)
  );

  ddce_timer u_timer (
    .clk  (clk),
    .rst  (rst),
    .tick (tick),
    .t    (tmr)
  );

  assign tmr.limit = win_steps;

  // ---------------------------------------------------------------
  // pair evaluation
  // ---------------------------------------------------------------
  ddce_state_t cls;
  ddce_state_t next_state;
  logic        next_armed;
  logic        next_enable;
  logic        next_timeout;
  logic        next_fault;
  logic        blocked;
  logic        next_blocked;
  logic        single;

  // both inputs from one source collapses to single-channel
  assign single = (mode == MODE_SINGLE);

  always_comb
  begin
    cls = ST_DISC;
    case ({in_a, in_b})
      2'b00:   cls = (mode == MODE_EQUIV) ? ST_DEACT : ST_DISC;
      2'b11:   cls = (mode == MODE_EQUIV) ? ST_ACTIVE : ST_DISC;
      2'b01:   cls = (mode == MODE_COMPL) ? ST_DEACT : ST_DISC;
      2'b10:   cls = (mode == MODE_COMPL) ? ST_ACTIVE : ST_DISC;
      default: cls = ST_DISC;
    endcase
  end

  always_comb
  begin
    next_state   = state;
    next_armed   = armed;
    next_timeout = timeout_err;
    next_blocked = blocked;
    tmr.start    = 1'b0;
    tmr.clear    = 1'b0;
    if (!run)
    begin
      next_state   = ST_DEACT;
      next_armed   = 1'b0;
      next_blocked = 1'b0;
      tmr.clear    = 1'b1;
    end
    else if (single)
    begin
      // no pairing and no timing in single-channel mode
      next_state   = in_a ? ST_ACTIVE : ST_DEACT;
      next_timeout = 1'b0;
      next_blocked = 1'b0;
      tmr.clear    = 1'b1;
    end
    else
    begin
      case (state)
        ST_DEACT:
        begin
          next_armed = 1'b1;
          tmr.clear  = 1'b1;
          if (cls == ST_DISC)
          begin
            next_state = ST_DISC;
            tmr.start  = 1'b1;
          end
          else if (cls == ST_ACTIVE)
            next_state = ST_ACTIVE;
        end
        ST_DISC:
        begin
          if (tmr.expired)
          begin
            next_state   = ST_ERROR;
            next_timeout = 1'b1;
          end
          else if (cls == ST_DEACT)
          begin
            next_state   = ST_DEACT;
            next_blocked = 1'b0;
          end
          else if (cls == ST_ACTIVE && armed)
            next_state = ST_ACTIVE;
          else if (cls == ST_ACTIVE)
            next_blocked = 1'b1;
        end
        ST_ACTIVE:
        begin
          tmr.clear = (cls == ST_ACTIVE);
          if (cls == ST_DISC)
          begin
            next_state = ST_DISC;
            tmr.start  = 1'b1;
          end
          else if (cls == ST_DEACT)
            next_state = ST_DEACT;
        end
        ST_ERROR:
        begin
          // error is left only through deactivation
          if (cls == ST_DEACT)
          begin
            next_state   = ST_DEACT;
            next_blocked = 1'b0;
            tmr.clear    = 1'b1;
          end
        end
        default:
          next_state = ST_DEACT;
      endcase
      if (next_state == ST_ACTIVE && state != ST_ACTIVE)
      begin
        next_armed   = 1'b0;
        next_timeout = 1'b0;
      end
    end
  end

  assign next_enable = (next_state == ST_ACTIVE) && run;
  assign next_fault  = run && !single && (next_state == ST_ERROR || next_blocked);

  // one evaluation per clock edge; reset lands deactivated, enable low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state       <= ST_DEACT;
      armed       <= 1'b0;
      enable      <= 1'b0;
      timeout_err <= 1'b0;
      fault_flag  <= 1'b0;
      blocked     <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      armed       <= next_armed;
      enable      <= next_enable;
      timeout_err <= next_timeout;
      fault_flag  <= next_fault;
      blocked     <= next_blocked;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_left_active;
    state == ST_ACTIVE ##1 state != ST_ACTIVE;
  endsequence

  sequence s_enter_disc;
    state != ST_DISC ##1 state == ST_DISC;
  endsequence

  a_enable_only_active: assert property (enable |-> state == ST_ACTIVE)
    else $error("enable high outside active state");
  a_error_sets_timeout: assert property ($rose(state == ST_ERROR) |-> timeout_err && !enable)
    else $error("error state without timeout or with enable");
  a_zero_window_quiet: assert property (win_steps == '0 |-> !tmr.expired ##1 state != ST_ERROR)
    else $error("timeout with zero window");
  a_timeout_clear: assert property ($rose(enable) && !single |-> !timeout_err)
    else $error("timeout not cleared on activation");
  a_timeout_hold: assert property ($past(state) inside {ST_DEACT, ST_DISC} && state inside {ST_DEACT, ST_DISC}
                                  |-> $stable(timeout_err))
    else $error("timeout changed while deactivated or discrepant");
  a_no_reentry: assert property (state == ST_DISC && !armed && run && !single |=> state != ST_ACTIVE)
    else $error("re-entered active without deactivation");
  a_fault_on_error: assert property (state == ST_ERROR |-> fault_flag)
    else $error("fault flag low in error state");
  a_single_pass: assert property (run && single ##1 run && single |-> enable == $past(in_a))
    else $error("single channel enable not following input");
  a_left_active: assert property (s_left_active |-> !enable)
    else $error("enable stayed high after leaving active");
  a_timer_restart: assert property (s_enter_disc |-> $past(tmr.start))
    else $error("timer not restarted on entering discrepant");
  a_cfg_static: assert property (run && $past(run) |-> $stable(mode) && $stable(win_steps))
    else $error("configuration changed while running");
endmodule

`default_nettype wire

// ---- bench/ddce_sensor.sv ----
`timescale 1ns/100ps
`default_nettype none

module ddce_sensor (
  // clock
  input  wire logic clk,
  // contacts
  output var  logic in_a,
  output var  logic in_b
);
  // ---------------------------------------------------------------
  // contact pair
  // ---------------------------------------------------------------
  initial
  begin
    in_a = 1'b0;
    in_b = 1'b0;
  end

  // contact b may trail a by lag cycles, as a worn switch does
  task automatic drive(input logic a, input logic b, input int lag);
    @(posedge clk);
    in_a <= a;
    if (lag > 0)
    begin
      repeat (lag) @(posedge clk);
    end
    in_b <= b;
  endtask
endmodule

`default_nettype wire

// ---- bench/test_dual_channel_discrepancy_eval.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_dual_channel_discrepancy_eval;
  import ddce_pkg::*;

  localparam int unsigned TICK = 4;
  localparam int unsigned WIN  = 5;

  logic              clk;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              in_a;
  logic              in_b;
  logic              enable;
  logic              timeout_err;
  logic              fault_flag;
  logic [DATA_W-1:0] rd;
  logic              er;
  int                fail_count;
  int                check_count;
  int                m_mode, m_st, m_arm, m_en, m_tmo, m_flt;

  ddce_eval #(.TICK_CYCLES(TICK)) u_ddce_eval (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_a(in_a), .in_b(in_b), .enable(enable),
    .timeout_err(timeout_err), .fault_flag(fault_flag)
  );

  ddce_sensor u_ddce_sensor (.clk(clk), .in_a(in_a), .in_b(in_b));

  initial
  begin
    clk = 1'b0;
  end

  always #5 clk = ~clk;

  // ---------------------------------------------------------------
  // report and compare
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("TB: checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_out();
    logic [2:0] exp;
    exp = {m_en[0], m_tmo[0], m_flt[0]};
    check_count++;
    if ({enable, timeout_err, fault_flag} !== exp)
    begin
      fail_count++;
      $display("unexpected outputs at %0t: got %h exp %h", $time,
               {enable, timeout_err, fault_flag}, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // apb master
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      fail_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk_word(rd, exp);
    chk_word({31'h0, er}, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic void m_step(input int a, input int b);
    int c;
    if (m_mode == 2)
    begin
      // single channel carries no timeout and no fault
      m_en  = a;
      m_tmo = 0;
      m_flt = 0;
      return;
    end
    if (m_mode == 0)
      c = (a && b) ? 2 : ((a || b) ? 1 : 0);
    else
      c = (a && !b) ? 2 : ((!a && b) ? 0 : 1);
    if (c == 0)
    begin
      m_st  = 0;
      m_arm = 1;
      m_flt = 0;
    end
    else if (m_st == 3 || (c == 2 && m_st == 2))
    begin
      m_st = m_st;
    end
    else if (c == 2 && m_arm == 1)
    begin
      m_st  = 2;
      m_arm = 0;
      m_tmo = 0;
      m_flt = 0;
    end
    else
    begin
      // refused ordering still counts as discrepant
      m_flt = (c == 2) ? 1 : m_flt;
      m_st  = 1;
    end
    m_en = (m_st == 2);
  endfunction

  function automatic void m_run();
    m_st  = 0;
    m_arm = 0;
    m_en  = 0;
  endfunction

  task automatic put(input int a, input int b, input int lag);
    if (lag > 0)
    begin
      m_step(a, int'(in_b));
    end
    u_ddce_sensor.drive(a[0], b[0], lag);
    repeat (2) @(posedge clk);
    #1;
    m_step(a, b);
    chk_out();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    check_count = 0;
    m_mode = 0;
    m_run();
    m_tmo = 0;
    m_flt = 0;
    void'($urandom(32'h74cbb91b));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_out();
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_WINDOW, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk_word({rd[30:0], er}, 32'h1);
    apb(1'b1, OFF_WINDOW, WIN);
    apb(1'b1, OFF_WINDOW, 32'd3001);
    rdchk(OFF_WINDOW, WIN);
    apb(1'b1, OFF_CTRL, 32'h6);
    rdchk(OFF_CTRL, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h1);
    m_run();
    put(0, 0, 0);
    put(1, 1, 3);
    put(0, 1, 0);
    put(1, 1, 0);
    put(0, 0, 0);
    put(1, 1, 0);
    put(1, 0, 0);
    // early check guards against a window of two steps or less
    repeat (10) @(posedge clk);
    chk_out();
    repeat (20) @(posedge clk);
    m_st = 3;
    m_en = 0;
    m_tmo = 1;
    m_flt = 1;
    chk_out();
    rdchk(OFF_STATUS, {24'h0, m_arm[0], m_flt[0], m_tmo[0], m_en[0], m_st[1:0], 2'b01});
    put(1, 1, 0);
    put(0, 0, 0);
    put(1, 1, 0);
    apb(1'b1, OFF_WINDOW, 32'h2);
    rdchk(OFF_WINDOW, WIN);
    apb(1'b1, OFF_CTRL, 32'h3);
    rdchk(OFF_CTRL, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_WINDOW, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h3);
    m_mode = 1;
    m_run();
    put(0, 1, 0);
    put(0, 0, 0);
    repeat (60) @(posedge clk);
    chk_out();
    // zero window keeps long random discrepancies legal
    for (int i = 0; i < 40; i++)
      put($urandom_range(1), $urandom_range(1), $urandom_range(2));
    put(0, 1, 0);
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h5);
    m_mode = 2;
    m_run();
    put(1, 0, 0);
    put(0, 1, 0);
    put(1, 1, 0);
    test_done();
  end
endmodule

`default_nettype wire
